// ---- sdr_bus_ctrl.v ----
`include "sdr_bus_defs.vh"
// Byte engine for the single-data-rate sideband bus. Write bytes come in
// through a FIFO; read bytes go out as one-cycle pulses on rd_valid.
// Start, stop and address phases are the job of the surrounding sequencer.
module sdr_bus_ctrl #(
  parameter [15:0] SCL_LOW  = `SCL_LOW_DEF,
  parameter [15:0] SCL_HIGH = `SCL_HIGH_DEF,
  parameter [15:0] HUB_DLY  = `HUB_DELAY_DEF
) (
  input  wire       ref_clk,
  input  wire       srst,
  input  wire       wr_valid,
  output wire       wr_ready,
  input  wire [7:0] wr_data,
  input  wire       wr_last,
  input  wire       rd_start,
  input  wire       rd_stop,
  output reg  [7:0] rd_data,
  output reg        rd_valid,
  output reg        rd_more,
  output reg        busy,
  output reg        scl_o,
  output reg        sda_o,
  output reg        sda_oe,
  output reg        sda_pu_en,
  input  wire       sda_i,
  input  wire       scl_i
);
  // Single-data-rate framing only; no high-rate or mixed modes. [RULE_13] [RULE_14]
  localparam [4:0] ST_IDLE  = 5'b00001;
  localparam [4:0] ST_WRITE = 5'b00010;
  localparam [4:0] ST_READ  = 5'b00100;
  localparam [4:0] ST_RTBIT = 5'b01000;
  localparam [4:0] ST_WLAST = 5'b10000;

  reg  [4:0]  state_q;
  reg  [15:0] tmr_q;
  reg         phase_hi_q;
  reg  [3:0]  bit_q;
  reg  [7:0]  shift_q;
  reg         par_q;
  reg         last_q;
  reg         stop_q;
  wire        sda_s;
  wire        scl_s;
  wire        f_valid;
  wire        f_ready;
  wire [8:0]  f_data;
  wire        tick;
  wire        rise;
  wire        fall;

  sync_fifo #(
    .WIDTH (9),
    .DEPTH (`FIFO_DEPTH_DEF),
    .AW    (`FIFO_AW_DEF)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   ({wr_last, wr_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  pin_sync #(.RESET_VAL (1'b1)) u_sda_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .pin_in  (sda_i),
    .level_q (sda_s)
  );

  // SCL is looped back only so its own level is seen; no target drives it.
  pin_sync #(.RESET_VAL (1'b1)) u_scl_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .pin_in  (scl_i),
    .level_q (scl_s)
  );

  assign f_ready = (state_q == ST_IDLE);
  // Phase timer: the high phase is stretched by the hub relay delay. [RULE_15]
  assign tick = (state_q != ST_IDLE) && (tmr_q == 16'd0); // [RULE_10]
  assign rise = tick && !phase_hi_q;
  assign fall = tick && phase_hi_q;

  always @(posedge ref_clk) begin
    if (srst) begin
      state_q    <= ST_IDLE;
      tmr_q      <= 16'd0;
      phase_hi_q <= 1'b0;
      bit_q      <= 4'd0;
      shift_q    <= 8'h00;
      par_q      <= 1'b1;
      last_q     <= 1'b0;
      stop_q     <= 1'b0;
      rd_data    <= 8'h00;
      rd_valid   <= 1'b0;
      rd_more    <= 1'b0;
      busy       <= 1'b0;
      scl_o      <= 1'b0;
      sda_o      <= 1'b1;
      sda_oe     <= 1'b0;
      sda_pu_en  <= 1'b1;
    end else begin
      rd_valid <= 1'b0;
      if (rd_stop) begin
        stop_q <= 1'b1;
      end
      if (state_q != ST_IDLE) begin
        if (tmr_q != 16'd0) begin
          tmr_q <= tmr_q - 16'd1;
        end else if (phase_hi_q) begin
          tmr_q <= SCL_LOW - 16'd1;
        end else begin
          tmr_q <= SCL_HIGH + HUB_DLY - 16'd1; // [RULE_15]
        end
        if (tick) begin
          phase_hi_q <= !phase_hi_q;
          scl_o      <= !phase_hi_q; // [RULE_10]
        end
      end
      case (state_q)
        ST_IDLE: begin
          scl_o      <= 1'b0;
          phase_hi_q <= 1'b0;
          bit_q      <= 4'd0;
          busy       <= 1'b0;
          sda_oe     <= 1'b0;
          sda_pu_en  <= 1'b1; // [RULE_12]
          if (f_valid) begin
            // Push-pull for the whole write byte and its ninth bit. [RULE_09]
            shift_q   <= f_data[7:0];
            last_q    <= f_data[8];
            par_q     <= ~^f_data[7:0]; // [RULE_08] [RULE_16]
            sda_o     <= f_data[7];
            sda_oe    <= 1'b1; // [RULE_04]
            sda_pu_en <= 1'b0; // [RULE_02]
            tmr_q     <= SCL_LOW - 16'd1;
            busy      <= 1'b1;
            state_q   <= ST_WRITE;
          end else if (rd_start) begin
            sda_oe    <= 1'b0; // [RULE_03]
            sda_pu_en <= 1'b0; // [RULE_02]
            stop_q    <= 1'b0;
            tmr_q     <= SCL_LOW - 16'd1;
            busy      <= 1'b1;
            state_q   <= ST_READ;
          end
        end
        ST_WRITE: begin
          if (fall) begin
            if (bit_q == `NINTH_BIT_IDX) begin
              // Back to open drain between bytes. [RULE_01]
              sda_oe    <= 1'b0;
              sda_pu_en <= 1'b1;
              state_q   <= ST_IDLE;
            end else if (bit_q == `BITS_PER_BYTE - 4'd1) begin
              sda_o <= par_q; // [RULE_08]
              bit_q <= bit_q + 4'd1; // [RULE_05]
            end else begin
              sda_o   <= shift_q[6];
              shift_q <= {shift_q[6:0], 1'b0};
              bit_q   <= bit_q + 4'd1;
            end
          end
        end
        ST_READ: begin
          if (fall) begin
            // The synchronised level lags the pin, so the target's bit is
            // taken at the end of the high phase, before it moves. [RULE_03]
            shift_q <= {shift_q[6:0], sda_s};
            if (bit_q == `BITS_PER_BYTE - 4'd1) begin
              sda_pu_en <= 1'b1; // [RULE_07] [RULE_01]
              // Pull low during the ninth bit to end the read. [RULE_06]
              sda_o     <= 1'b0;
              sda_oe    <= stop_q;
              bit_q     <= `NINTH_BIT_IDX;
              state_q   <= ST_RTBIT;
            end else begin
              bit_q <= bit_q + 4'd1;
            end
          end
        end
        ST_RTBIT: begin
          if (fall) begin
            bit_q    <= 4'd0;
            rd_data  <= shift_q;
            rd_more  <= sda_s & !stop_q; // [RULE_06]
            rd_valid <= 1'b1;
            if ((sda_s & !stop_q) == `READ_CONTINUE) begin
              sda_pu_en <= 1'b0; // [RULE_07] [RULE_02]
              sda_oe    <= 1'b0;
              state_q   <= ST_READ;
            end else begin
              sda_oe  <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // sdr_bus_ctrl

// ---- sdr_bus_defs.vh ----
// Operation
// RULE_01 - Strong pull-up on during open-drain phases.
// RULE_02 - Push-pull: pull-up off, one driver.
// RULE_03 - Read data bits: controller releases SDA.
// RULE_04 - Write data bits driven with own SCL.
// RULE_05 - Each byte is eight bits plus ninth.
// RULE_06 - Read ninth bit: target continues, controller ends.
// RULE_07 - Read ninth bit runs open drain.
// RULE_08 - Write ninth bit carries byte parity.
// RULE_09 - Write stays push-pull through ninth bit.
// RULE_10 - Controller always drives SCL, sets phases.
// RULE_11 - Targets never drive SCL.
// RULE_12 - Open drain where targets may pull low.
// RULE_13 - Single data rate is the default mode.
// RULE_14 - No high data rate, mixed mode, hot-join.
// RULE_15 - Timing allows hub relay delay.
// RULE_16 - Write parity is odd parity.
`ifndef SDR_BUS_DEFS_VH
`define SDR_BUS_DEFS_VH
`define BITS_PER_BYTE     4'd8
`define NINTH_BIT_IDX     4'd8
`define LAST_BIT_IDX      4'd8
`define SCL_LOW_DEF       16'd50
`define SCL_HIGH_DEF      16'd50
`define HUB_DELAY_DEF     16'd4
`define FIFO_WIDTH_DEF    8
`define FIFO_DEPTH_DEF    32
`define FIFO_AW_DEF       5
`define READ_CONTINUE     1'b1
`endif

// ---- sync_fifo.v ----
`include "sdr_bus_defs.vh"
module sync_fifo #(
  parameter WIDTH = `FIFO_WIDTH_DEF,
  parameter DEPTH = `FIFO_DEPTH_DEF,
  parameter AW    = `FIFO_AW_DEF
) (
  input  wire             ref_clk,
  input  wire             srst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @* begin
    out_data = mem[rd_q];
  end
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
    if (srst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // sync_fifo

// ---- pin_sync.v ----
// Three-stage sampler; the output moves once stages two and three agree.
module pin_sync #(
  parameter RESET_VAL = 1'b1
) (
  input  wire ref_clk,
  input  wire srst,
  input  wire pin_in,
  output reg  level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge ref_clk) begin
    if (srst) begin
      s1_q    <= RESET_VAL;
      s2_q    <= RESET_VAL;
      s3_q    <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule // pin_sync

// ---- sdr_bus_ctrl_properties.sv ----
module sdr_bus_ctrl_properties #(
  parameter [15:0] SCL_LOW  = 16'd50,
  parameter [15:0] SCL_HIGH = 16'd50,
  parameter [15:0] HUB_DLY  = 16'd4
) (
  input logic ref_clk,
  input logic srst,
  input logic rd_valid,
  input logic busy,
  input logic scl_o,
  input logic sda_o,
  input logic sda_oe,
  input logic sda_pu_en
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HI = SCL_HIGH + HUB_DLY;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_idle_release: assert property (
    !busy |-> sda_pu_en && !sda_oe) else $error("idle sda held");
  a_high_no_pu: assert property (
    sda_oe && sda_o |-> !sda_pu_en) else $error("pull-up while driving");
  a_od_low_only: assert property (
    sda_oe && sda_pu_en |-> !sda_o) else $error("drove high in od");
  a_sda_scl_low: assert property (
    sda_oe && $changed(sda_o) |-> !scl_o) else $error("sda moved, scl high");
  a_scl_high_len: assert property (
    $rose(scl_o) |-> ##HI $fell(scl_o)) else $error("scl high length");
  a_scl_low_len: assert property (
    $rose(scl_o) |-> $past(scl_o, SCL_LOW) == 1'b0) else $error("scl low");
  a_scl_when_busy: assert property (
    scl_o |-> busy) else $error("scl high while idle");
  a_rd_pulse: assert property (
    rd_valid |=> !rd_valid) else $error("rd_valid too long");
  a_rd_ninth_od: assert property (
    rd_valid |-> $past(sda_pu_en)) else $error("ninth bit not od");
  a_write_pp_hold: assert property (
    sda_oe && !sda_pu_en |=> sda_oe || sda_pu_en) else $error("pp gap");
endmodule // sdr_bus_ctrl_properties

bind sdr_bus_ctrl sdr_bus_ctrl_properties #(
  .SCL_LOW(SCL_LOW), .SCL_HIGH(SCL_HIGH), .HUB_DLY(HUB_DLY)
) u_props (
  .ref_clk(ref_clk), .srst(srst), .rd_valid(rd_valid), .busy(busy),
  .scl_o(scl_o), .sda_o(sda_o), .sda_oe(sda_oe), .sda_pu_en(sda_pu_en)
);

// ---- sdr_target_model.sv ----
module sdr_target_model (
  input  logic        clr,
  input  logic        scl,
  input  logic        sda,
  input  logic        rd_mode,
  input  logic [15:0] rd_word,
  input  logic [1:0]  rd_more_in,
  output logic        tgt_oe,
  output logic        tgt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] sh;
  logic [3:0] bitn;
  logic [3:0] fidx;
  logic       rbn;
  logic [8:0] rx_mem [0:63];
  int         rx_cnt;
  always @(posedge scl or posedge clr) begin
    if (clr) begin
      bitn <= 4'h0;
      rx_cnt <= 0;
    end else if (!rd_mode) begin
      sh <= {sh[7:0], sda};
      bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
      if (bitn == 4'h8) begin
        rx_mem[rx_cnt] <= {sh[7:0], sda};
        rx_cnt <= rx_cnt + 1;
      end
    end
  end
  // Bits move only on SCL falls; byte select flips after each ninth bit.
  always @(negedge scl or negedge rd_mode) begin
    if (!rd_mode) begin
      fidx <= 4'h0;
      rbn <= 1'b0;
    end else if (fidx == 4'h8) begin
      fidx <= 4'h0;
      rbn <= ~rbn;
    end else begin
      fidx <= fidx + 4'h1;
    end
  end
  // A last byte pulls the ninth bit low; more data lets the pull-up win.
  assign tgt_oe = rd_mode && (fidx != 4'h8 || !rd_more_in[rbn]);
  assign tgt_o  = (fidx != 4'h8) && rd_word[{~rbn, 3'h7 - fidx[2:0]}];
endmodule // sdr_target_model

// ---- sdr_bus_ctrl_tb.sv ----
module sdr_bus_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        wr_valid = 1'b0;
  logic        wr_last = 1'b0;
  logic        rd_start = 1'b0;
  logic        rd_stop = 1'b0;
  logic        rd_mode = 1'b0;
  logic [7:0]  wr_data = 8'h00;
  logic [15:0] rd_word = 16'h0000;
  logic [1:0]  rd_more_in = 2'b00;
  logic        wr_ready, rd_valid, rd_more, busy, scl_o, sda_o;
  logic        sda_oe, sda_pu_en, tgt_oe, tgt_o, sda;
  logic [7:0]  rd_data;
  int          n_fail = 0;
  int          tests_run = 0;
  always #2.5 ref_clk = ~ref_clk;
  assign sda = sda_oe ? sda_o : (tgt_oe ? tgt_o : 1'b1);
  sdr_bus_ctrl #(.SCL_LOW(16'd4), .SCL_HIGH(16'd4), .HUB_DLY(16'd1)) DUT (
    .ref_clk(ref_clk), .srst(srst), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .wr_last(wr_last),
    .rd_start(rd_start), .rd_stop(rd_stop), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_more(rd_more), .busy(busy), .scl_o(scl_o),
    .sda_o(sda_o), .sda_oe(sda_oe), .sda_pu_en(sda_pu_en), .sda_i(sda),
    .scl_i(scl_o)
  );
  sdr_target_model u_tgt (
    .clr(srst), .scl(scl_o), .sda(sda), .rd_mode(rd_mode),
    .rd_word(rd_word), .rd_more_in(rd_more_in), .tgt_oe(tgt_oe),
    .tgt_o(tgt_o)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d failures=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk) if (sda_oe && tgt_oe && sda_o) chk(1, 0);
  task automatic t_fill();
    for (int i = 0; i < 33; i++) begin
      @(negedge ref_clk);
      wr_valid = 1'b1;
      wr_data = 8'(i * 37);
      wr_last = (i == 32);
      while (wr_ready !== 1'b1) @(negedge ref_clk);
    end
    @(negedge ref_clk);
    chk(wr_ready, 0);
    wr_valid = 1'b0;
    repeat (4000) if (u_tgt.rx_cnt < 33) @(posedge ref_clk);
    repeat (200) if (busy !== 1'b0) @(negedge ref_clk);
    @(negedge ref_clk);
    chk(busy, 0);
    for (int i = 0; i < 33; i++)
      chk(u_tgt.rx_mem[i], {8'(i * 37), ~^8'(i * 37)});
  endtask
  task automatic t_read(input logic stop, input logic [1:0] more,
                        input int n, input logic [15:0] w);
    int i;
    rd_word = w;
    rd_more_in = more;
    rd_mode = 1'b1;
    @(negedge ref_clk) rd_start = 1'b1;
    @(negedge ref_clk) rd_start = 1'b0;
    rd_stop = stop;
    @(negedge ref_clk) rd_stop = 1'b0;
    for (int k = 0; k < n; k++) begin
      i = 0;
      while (rd_valid !== 1'b1 && i++ < 3000) @(negedge ref_clk);
      chk(rd_valid, 1);
      chk(rd_data, k ? w[7:0] : w[15:8]);
      chk(rd_more, !stop && more[k]);
      @(negedge ref_clk);
    end
    i = 0;
    while (busy !== 1'b0 && i++ < 3000) @(negedge ref_clk);
    chk(busy, 0);
    rd_mode = 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) srst = 1'b0;
    chk({scl_o, sda_oe, sda_o, sda_pu_en, busy, rd_valid}, 6'b001100);
    t_fill();
    t_read(1'b0, 2'b01, 2, 16'hc33c);
    t_read(1'b1, 2'b11, 1, 16'h0ff0);
    final_report();
  end
  initial begin
    #100000;
    chk(0, 1);
    final_report();
  end
endmodule // sdr_bus_ctrl_tb
